// ==== rtl/lle_pkg.sv ====
// Constants, types and size decode for the logical-layer error block
// What this block does
// - Flag port-write with bad payload size
// - Port-write size errors raise no standard error
// - Drop port-write when disabled or buffer full
// - Enabled port-write flags drive interrupt output
// - Port-write transmission signals no errors
// - ERROR response declares IO error response
// - Unmatched response declares unsolicited response
// - No response in time declares time-out
// - Malformed response declares illegal decode
// - Four slave flags drive interrupt when enabled
// - Slave read error on error, time-out, miss
// - Errored read burst still delivers every beat
// - Unsupported request type declares unsupported transaction
// - Short, priority 3, empty write, reserved size
// - Payload length must match encoded size
// - NREAD payload, partial lanes, window miss illegal
// - Read master uses all lanes, no enables
// - Illegal NREAD, NWRITE_R, atomic get ERROR response
// - Read error on last beat gives ERROR
// - Untargeted good-CRC packets go to pass-through
package lle_pkg;
   localparam logic [3:0] ST_DONE     = 4'h0;
   localparam logic [3:0] ST_ERROR    = 4'h7;
   localparam logic [3:0] TT_NOPL     = 4'h0;
   localparam logic [3:0] TT_PL       = 4'h8;
   localparam logic [8:0] PW_MAX_B    = 9'h040;
   localparam logic [4:0] MAX_BURST   = 5'h10;
   localparam int         FLAG_N      = 6;
   localparam int         FL_PW_ERR   = 0;
   localparam int         FL_PW_DROP  = 1;
   localparam int         FL_BAD_BE   = 2;
   localparam int         FL_BAD_BC   = 3;
   localparam int         FL_WR_MISS  = 4;
   localparam int         FL_RD_MISS  = 5;
   localparam logic [5:0] FLAGS_RST   = 6'h00;
   localparam logic [7:0] TID_RST     = 8'h00;
   localparam logic       PT_ENABLE   = 1'b1;
   localparam logic       MSG_SRC     = 1'b1;
   localparam logic       MSG_DST     = 1'b0;

   typedef enum logic [2:0] {
      KIND_NREAD   = 3'b000,
      KIND_NWRITE  = 3'b001,
      KIND_NWRITER = 3'b010,
      KIND_SWRITE  = 3'b011,
      KIND_ATOMIC5 = 3'b100,
      KIND_OTHER   = 3'b101
   } lle_kind_e;

   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_WAIT  = 2'b01,
      S_BEATS = 2'b10
   } lle_state_e;

   typedef struct packed {
      logic [8:0] pl_bytes;
      logic [3:0] wrsize;
      logic       wdptr;
   } lle_pw_s;

   typedef struct packed {
      logic [7:0]  tid;
      logic [3:0]  status;
      logic [3:0]  ttype;
      logic [8:0]  pl_bytes;
      logic [31:0] data;
   } lle_rsp_s;

   typedef struct packed {
      lle_kind_e   kind;
      logic [7:0]  tid;
      logic [1:0]  prio;
      logic [3:0]  size;
      logic        wdptr;
      logic [31:0] addr;
      logic [8:0]  pl_bytes;
      logic        too_short;
   } lle_req_s;

   typedef struct packed {
      logic io_err;
      logic unsol;
      logic timeout;
      logic illegal;
      logic unsupported;
   } lle_err_s;

   // Size field to byte count, zero for reserved codes
   function automatic logic [8:0] lle_size_bytes(input logic [3:0] sz, input logic wdptr, input logic rd);
      logic [8:0] r;
      r = 9'h000;
      case (sz)
         4'h0, 4'h1, 4'h2, 4'h3: r = 9'h001;
         4'h4, 4'h6:             r = 9'h002;
         4'h5:                   r = 9'h003;
         4'h7:                   r = 9'h005;
         4'h8:                   r = 9'h004;
         4'h9:                   r = 9'h006;
         4'ha:                   r = 9'h007;
         4'hb:                   r = wdptr ? 9'h010 : 9'h008;
         4'hc:                   r = wdptr ? 9'h040 : 9'h020;
         4'hd:                   r = wdptr ? 9'h080 : 9'h060;
         4'he:                   r = rd ? (wdptr ? 9'h0c0 : 9'h0a0) : 9'h000;
         default:                r = wdptr ? 9'h100 : (rd ? 9'h0e0 : 9'h000);
      endcase
      return r;
   endfunction : lle_size_bytes
endpackage : lle_pkg

// ==== rtl/lle_error_top.sv ====
// Logical-layer error detection and reporting
`timescale 1ns/1ps
module lle_error_top
   import lle_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              pw_rx_valid,
   input  wire lle_pw_s           pw_rx,
   input  wire logic              pw_receive_allow,
   input  wire logic              pw_buf_full,
   output logic                   pw_rx_accept,
   input  wire logic [FLAG_N-1:0] int_en,
   input  wire logic [FLAG_N-1:0] flag_clr,
   output logic [FLAG_N-1:0]      flags,
   output logic                   irq,
   input  wire logic              win_en,
   input  wire logic [31:0]       win_base,
   input  wire logic [31:0]       win_mask,
   input  wire logic [23:0]       rsp_timeout,
   input  wire logic              s_rd_read,
   input  wire logic [31:0]       s_rd_addr,
   input  wire logic [4:0]        s_rd_burstcount,
   output logic                   s_rd_waitrequest,
   output logic                   s_rd_datavalid,
   output logic [31:0]            s_rd_readdata,
   output logic                   s_rd_readerror,
   input  wire logic              s_wr_write,
   input  wire logic [31:0]       s_wr_addr,
   input  wire logic [3:0]        s_wr_byteenable,
   input  wire logic [4:0]        s_wr_burstcount,
   output logic                   s_wr_waitrequest,
   output logic                   s_req_valid,
   output lle_kind_e              s_req_kind,
   output logic [7:0]             s_req_tid,
   output logic [31:0]            s_req_addr,
   input  wire logic              rsp_valid,
   input  wire lle_rsp_s          rsp,
   input  wire logic              req_valid,
   input  wire lle_req_s          req,
   input  wire logic [5:0]        dest_ops,
   output logic                   m_ill_rsp_valid,
   output logic [7:0]             m_ill_rsp_tid,
   input  wire logic              m_rd_datavalid,
   input  wire logic              m_rd_last,
   input  wire logic              m_rd_readerror,
   output logic                   m_rd_rsp_valid,
   output logic [3:0]             m_rd_rsp_status,
   output lle_err_s               err_decl,
   output logic [7:0]             err_tid,
   input  wire logic              rx_pkt_valid,
   input  wire logic              rx_crc_ok,
   input  wire logic              rx_targeted,
   output logic                   pt_rx_fwd,
   input  wire logic              pt_tx_error,
   output logic                   pt_tx_abort,
   input  wire logic [3:0]        msg_err_in,
   output logic [3:0]             msg_err_out
);
   // ----------------------------------------
   // Port-write reception
   // ----------------------------------------
   logic [8:0]        pw_exp;
   logic              pw_bad;
   logic              pw_drop;
   logic [FLAG_N-1:0] flag_set;
   logic [FLAG_N-1:0] flag_keep;

   assign pw_exp  = lle_size_bytes(pw_rx.wrsize, pw_rx.wdptr, 1'b0);
   assign pw_bad  = pw_rx.pl_bytes == 9'h000 || pw_rx.pl_bytes > PW_MAX_B || pw_rx.pl_bytes > pw_exp;
   assign pw_drop = !pw_receive_allow || pw_buf_full;

   // ----------------------------------------
   // Slave address checks
   // ----------------------------------------
   logic       rd_hit;
   logic       wr_hit;
   logic       m_hit;
   logic       be_ok;
   logic       bc_ok;
   lle_state_e st;
   logic       rd_take;
   logic       wr_take;
   logic       wr_good;

   assign rd_hit  = win_en && ((s_rd_addr & win_mask) == (win_base & win_mask));
   assign wr_hit  = win_en && ((s_wr_addr & win_mask) == (win_base & win_mask));
   assign m_hit   = win_en && ((req.addr & win_mask) == (win_base & win_mask));
   assign be_ok   = s_wr_byteenable inside {4'hf, 4'h3, 4'hc, 4'h1, 4'h2, 4'h4, 4'h8};
   assign bc_ok   = s_wr_burstcount != 5'h00 && s_wr_burstcount <= MAX_BURST;
   assign rd_take = s_rd_read && st == S_IDLE;
   assign wr_take = s_wr_write && st == S_IDLE && !s_rd_read;
   assign wr_good = wr_take && wr_hit && be_ok && bc_ok;

   assign s_rd_waitrequest = st != S_IDLE;
   assign s_wr_waitrequest = st != S_IDLE || s_rd_read;

   assign flag_set[FL_PW_ERR]  = pw_rx_valid && pw_bad;
   assign flag_set[FL_PW_DROP] = pw_rx_valid && !pw_bad && pw_drop;
   assign flag_set[FL_BAD_BE]  = wr_take && !be_ok;
   assign flag_set[FL_BAD_BC]  = wr_take && !bc_ok;
   assign flag_set[FL_WR_MISS] = wr_take && !wr_hit;
   assign flag_set[FL_RD_MISS] = rd_take && !rd_hit;
   assign flag_keep            = flags & ~flag_clr;

   // ----------------------------------------
   // Slave response checks
   // ----------------------------------------
   logic        cur_rd;
   logic [7:0]  cur_tid;
   logic [4:0]  cur_beats;
   logic [4:0]  beats_left;
   logic        beat_err;
   logic [23:0] tmr;
   logic        rsp_match;
   logic        rsp_unsol;
   logic        bad_status;
   logic        pl_bad;
   logic        ill_s;
   logic        io_err;
   logic        tmo;
   logic        rsp_fail;

   assign rsp_match  = rsp_valid && st == S_WAIT && rsp.tid == cur_tid;
   assign rsp_unsol  = rsp_valid && !rsp_match;
   assign bad_status = rsp.status != ST_DONE && rsp.status != ST_ERROR;
   assign pl_bad     = cur_rd ? (rsp.ttype != TT_PL || rsp.pl_bytes != 9'({cur_beats, 2'b00}))
                              : (rsp.ttype != TT_NOPL || rsp.pl_bytes != 9'h000);
   assign ill_s      = rsp_match && (bad_status || pl_bad);
   assign io_err     = rsp_match && !ill_s && rsp.status == ST_ERROR;
   assign tmo        = st == S_WAIT && !rsp_match && tmr >= rsp_timeout;
   assign rsp_fail   = io_err || ill_s || tmo;

   assign s_rd_datavalid = st == S_BEATS;
   assign s_rd_readerror = st == S_BEATS && beat_err;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st         <= S_IDLE;
         cur_rd     <= 1'b0;
         cur_tid    <= TID_RST;
         cur_beats  <= 5'h00;
         beats_left <= 5'h00;
         beat_err   <= 1'b0;
         tmr        <= 24'h000000;
         s_req_valid <= 1'b0;
         s_req_kind <= KIND_NREAD;
         s_req_tid  <= TID_RST;
         s_req_addr <= 32'h00000000;
         s_rd_readdata <= 32'h00000000;
      end
      else
      begin
         s_req_valid <= 1'b0;
         unique case (st)
            S_IDLE:
            begin
               tmr <= 24'h000000;
               if (rd_take && !rd_hit)
               begin
                  st         <= S_BEATS;
                  beat_err   <= 1'b1;
                  beats_left <= s_rd_burstcount;
               end
               else if (rd_take || wr_good)
               begin
                  st          <= S_WAIT;
                  cur_rd      <= rd_take;
                  cur_beats   <= s_rd_burstcount;
                  cur_tid     <= s_req_tid;
                  s_req_valid <= 1'b1;
                  s_req_kind  <= rd_take ? KIND_NREAD : KIND_NWRITER;
                  s_req_addr  <= rd_take ? s_rd_addr : s_wr_addr;
               end
            end
            S_WAIT:
            begin
               tmr <= tmr + 24'h000001;
               if (rsp_match || tmo)
               begin
                  s_req_tid     <= s_req_tid + 8'h01;
                  s_rd_readdata <= rsp.data;
                  beat_err      <= rsp_fail;
                  beats_left    <= cur_beats;
                  st            <= cur_rd ? S_BEATS : S_IDLE;
               end
            end
            default:
            begin
               beats_left <= beats_left - 5'h01;
               if (beats_left <= 5'h01)
               begin
                  st <= S_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Master request checks
   // ----------------------------------------
   logic       m_sup;
   logic [8:0] m_exp;
   logic       m_is_wr;
   logic       m_is_rd;
   logic       m_addr_kind;
   logic       m_ill;

   assign m_sup       = dest_ops[req.kind] && req.kind != KIND_OTHER;
   assign m_is_rd     = req.kind == KIND_NREAD;
   assign m_is_wr     = req.kind == KIND_NWRITE || req.kind == KIND_NWRITER;
   assign m_addr_kind = m_is_rd || m_is_wr || req.kind == KIND_SWRITE;
   assign m_exp       = lle_size_bytes(req.size, req.wdptr, m_is_rd);
   assign m_ill       = req.too_short || req.prio == 2'h3 || (m_is_wr && req.pl_bytes == 9'h000)
                        || (m_is_wr && m_exp == 9'h000)
                        || (m_is_wr && req.pl_bytes != m_exp)
                        || (m_is_rd && req.pl_bytes != 9'h000)
                        || (m_is_rd && (m_exp == 9'h000 || m_exp[1:0] != 2'b00))
                        || (m_addr_kind && !m_hit);

   // ----------------------------------------
   // Flags, declarations, responses, pass-through
   // ----------------------------------------
   assign irq = |(flags & int_en);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flags           <= FLAGS_RST;
         pw_rx_accept    <= 1'b0;
         err_decl        <= '0;
         err_tid         <= TID_RST;
         m_ill_rsp_valid <= 1'b0;
         m_ill_rsp_tid   <= TID_RST;
         m_rd_rsp_valid  <= 1'b0;
         m_rd_rsp_status <= ST_DONE;
         pt_rx_fwd       <= 1'b0;
         pt_tx_abort     <= 1'b0;
         msg_err_out     <= 4'h0;
      end
      else
      begin
         flags        <= flag_keep | flag_set;
         pw_rx_accept <= pw_rx_valid && !pw_bad && !pw_drop;
         // Port-write paths feed no standard error term
         err_decl.io_err      <= io_err;
         err_decl.unsol       <= rsp_unsol;
         err_decl.timeout     <= tmo;
         err_decl.illegal     <= ill_s || (req_valid && m_sup && m_ill);
         err_decl.unsupported <= req_valid && !m_sup;
         err_tid              <= req_valid ? req.tid : (rsp_valid ? rsp.tid : cur_tid);
         m_ill_rsp_valid      <= req_valid && m_sup && m_ill
                                 && (m_is_rd || req.kind == KIND_NWRITER || req.kind == KIND_ATOMIC5);
         m_ill_rsp_tid        <= req.tid;
         m_rd_rsp_valid       <= m_rd_datavalid && m_rd_last;
         m_rd_rsp_status      <= m_rd_readerror ? ST_ERROR : ST_DONE;
         pt_rx_fwd            <= rx_pkt_valid && rx_crc_ok && !rx_targeted;
         pt_tx_abort          <= pt_tx_error;
         msg_err_out          <= (PT_ENABLE && (MSG_SRC || MSG_DST)) ? msg_err_in : 4'h0;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_err_burst2;
      s_rd_readerror [*2] ##1 !s_rd_datavalid;
   endsequence

   property p_pw_err;
      pw_rx_valid && pw_bad |=> flags[FL_PW_ERR];
   endproperty
   a_pw_err: assert property (p_pw_err) else $error("port-write size error not flagged");

   property p_pw_nostd;
      pw_rx_valid && !rsp_valid && !req_valid && st != S_WAIT |=> err_decl == '0;
   endproperty
   a_pw_nostd: assert property (p_pw_nostd) else $error("port-write raised standard error");

   property p_pw_drop;
      pw_rx_valid && !pw_bad && !pw_receive_allow |=> flags[FL_PW_DROP] && !pw_rx_accept;
   endproperty
   a_pw_drop: assert property (p_pw_drop) else $error("disabled port-write not dropped");

   property p_irq;
      |(flag_set & int_en) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("enabled flag did not raise interrupt");

   property p_unsol;
      rsp_valid && st != S_WAIT |=> err_decl.unsol;
   endproperty
   a_unsol: assert property (p_unsol) else $error("unsolicited response not declared");

   property p_tmo;
      st == S_WAIT && !rsp_valid && tmr >= rsp_timeout |=> err_decl.timeout;
   endproperty
   a_tmo: assert property (p_tmo) else $error("time-out not declared");

   property p_rd_miss;
      rd_take && !rd_hit |=> s_rd_readerror && flags[FL_RD_MISS];
   endproperty
   a_rd_miss: assert property (p_rd_miss) else $error("read miss without read error");

   property p_burst;
      rd_take && !rd_hit && s_rd_burstcount == 5'h02 |=> s_err_burst2;
   endproperty
   a_burst: assert property (p_burst) else $error("errored burst beat count wrong");

   property p_unsup;
      req_valid && !dest_ops[req.kind] |=> err_decl.unsupported;
   endproperty
   a_unsup: assert property (p_unsup) else $error("unsupported type not declared");

   property p_prio3;
      req_valid && m_sup && req.prio == 2'h3 |=> err_decl.illegal;
   endproperty
   a_prio3: assert property (p_prio3) else $error("priority 3 not illegal");

   property p_atomic;
      req_valid && m_sup && req.kind == KIND_ATOMIC5 && (req.too_short || req.prio == 2'h3) |=> m_ill_rsp_valid;
   endproperty
   a_atomic: assert property (p_atomic) else $error("no ERROR response for bad atomic");

   property p_rd_rsp;
      m_rd_datavalid && m_rd_last && m_rd_readerror |=> m_rd_rsp_valid && m_rd_rsp_status == ST_ERROR;
   endproperty
   a_rd_rsp: assert property (p_rd_rsp) else $error("read error not returned");

   property p_fwd;
      rx_pkt_valid && rx_crc_ok && !rx_targeted |=> pt_rx_fwd;
   endproperty
   a_fwd: assert property (p_fwd) else $error("untargeted packet not forwarded");

   property p_sticky;
      1'b1 |=> (flags & $past(flag_keep)) == $past(flag_keep);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag cleared without software");
endmodule : lle_error_top

// ==== verification/lle_far_end.sv ====
// Remote endpoint model that answers slave requests
`timescale 1ns/1ps
module lle_far_end
   import lle_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       s_req_valid,
   input  wire lle_kind_e  s_req_kind,
   input  wire logic [7:0] s_req_tid,
   input  wire logic [1:0] mode,
   input  wire logic [8:0] pl,
   input  wire logic       kick,
   output logic            rsp_valid,
   output lle_rsp_s        rsp
);
   // ----------------------------------------
   // Answer: 0 done, 1 error, 2 silent, 3 bad status
   // ----------------------------------------
   logic [7:0] tid;
   logic [3:0] cnt;
   logic       nrd;

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt       <= 4'h0;
         tid       <= 8'h00;
         nrd       <= 1'b0;
         rsp_valid <= 1'b0;
         rsp       <= '0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         if (rsp_valid)
            rsp <= ~rsp;
         if (s_req_valid && mode != 2'h2)
         begin
            cnt <= 4'h3;
            tid <= s_req_tid;
            nrd <= (s_req_kind == KIND_NREAD);
         end
         else if (cnt == 4'h1 || kick)
         begin
            rsp_valid    <= 1'b1;
            rsp.tid      <= kick ? 8'h5a : tid;
            rsp.status   <= (mode == 2'h1) ? ST_ERROR : ((mode == 2'h3) ? 4'h3 : ST_DONE);
            rsp.ttype    <= nrd ? TT_PL : TT_NOPL;
            rsp.pl_bytes <= nrd ? pl : 9'h000;
            rsp.data     <= 32'hc0de0001;
         end
         if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
      end
   end
endmodule : lle_far_end

// ==== verification/tb_top.sv ====
// Self-checking testbench for the logical-layer error block
`timescale 1ns/1ps
module tb_top;
   import lle_pkg::*;
   logic ref_clk, rst_n, pw_rx_valid, pw_receive_allow, pw_buf_full, win_en, s_rd_read, s_wr_write;
   logic req_valid, m_rd_datavalid, m_rd_last, m_rd_readerror, rx_pkt_valid, rx_crc_ok, rx_targeted;
   logic pt_tx_error, pw_rx_accept, irq, s_rd_waitrequest, s_rd_datavalid, s_rd_readerror;
   logic s_wr_waitrequest, s_req_valid, m_ill_rsp_valid, m_rd_rsp_valid, pt_rx_fwd, pt_tx_abort, rsp_valid;
   logic [5:0]  int_en, flag_clr, dest_ops, flags;
   logic [31:0] win_base, win_mask, s_rd_addr, s_wr_addr, s_rd_readdata, s_req_addr;
   logic [23:0] rsp_timeout;
   logic [4:0]  s_rd_burstcount, s_wr_burstcount;
   logic [3:0]  s_wr_byteenable, msg_err_in, msg_err_out, m_rd_rsp_status;
   logic [7:0]  s_req_tid, m_ill_rsp_tid, err_tid;
   logic [1:0]  fe_mode;
   logic [8:0]  fe_pl;
   logic        fe_kick;
   lle_kind_e   s_req_kind;
   lle_pw_s     pw_rx;
   lle_req_s    req;
   lle_rsp_s    rsp;
   lle_err_s    err_decl, err_seen;
   int          n_mismatch, n_compared, cyc;

   lle_error_top DUT (.*);
   lle_far_end u_far (.ref_clk(ref_clk), .rst_n(rst_n), .s_req_valid(s_req_valid), .s_req_kind(s_req_kind),
      .s_req_tid(s_req_tid), .mode(fe_mode), .pl(fe_pl), .kick(fe_kick), .rsp_valid(rsp_valid), .rsp(rsp));

   // ----------------------------------------
   // Clock, capture and watchdog
   // ----------------------------------------
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      err_seen <= (!rst_n || flag_clr == 6'h3f) ? '0 : (err_seen | err_decl);
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic chkf(input logic [5:0] ef);
      chk(flags, ef);
      chk(irq, |(ef & int_en));
   endtask : chkf

   task automatic clr(input string s);
      flag_clr = 6'h3f;
      @(negedge ref_clk);
      flag_clr = 6'h00;
      $display("test %s done", s);
   endtask : clr

   // ----------------------------------------
   // Scenario tasks
   // ----------------------------------------
   task automatic pw(input logic [8:0] b, input logic al, input logic fu, input logic [5:0] ef, input logic ea);
      pw_rx = '{b, 4'hb, 1'b0};
      pw_receive_allow = al;
      pw_buf_full = fu;
      pw_rx_valid = 1'b1;
      @(negedge ref_clk);
      pw_rx_valid = 1'b0;
      chk(pw_rx_accept, ea);
      @(negedge ref_clk);
      chkf(ef);
      chk(err_seen, 5'h00);
      clr("port_write");
   endtask : pw

   task automatic rd(input logic [31:0] a, input logic [4:0] bc, input logic [1:0] m, input logic ee);
      int beats;
      beats = 0;
      fe_mode = m;
      fe_pl = {2'b00, bc, 2'b00};
      s_rd_addr = a;
      s_rd_burstcount = bc;
      s_rd_read = 1'b1;
      @(negedge ref_clk);
      s_rd_read = 1'b0;
      chk(s_rd_waitrequest, 1'b1);
      chk(s_wr_waitrequest, 1'b1);
      for (int i = 0; i < 200 && beats < bc; i++)
      begin
         if (s_rd_datavalid === 1'b1)
         begin
            beats++;
            chk(s_rd_readerror, ee);
         end
         @(negedge ref_clk);
      end
      chk(beats, bc);
      chk(s_rd_datavalid, 1'b0);
   endtask : rd

   task automatic wr(input logic [31:0] a, input logic [3:0] be, input logic [4:0] bc, input logic [5:0] ef);
      fe_mode = 2'h0;
      s_wr_addr = a;
      s_wr_byteenable = be;
      s_wr_burstcount = bc;
      s_wr_write = 1'b1;
      @(negedge ref_clk);
      s_wr_write = 1'b0;
      repeat (8) @(negedge ref_clk);
      chkf(ef);
      chk(err_seen, 5'h00);
      clr("slave_write");
   endtask : wr

   task automatic mreq(input lle_kind_e k, input logic [1:0] p, input logic [8:0] b, input logic [31:0] a,
                       input logic [4:0] ee, input logic ei);
      req = '{k, 8'h33, p, 4'hb, 1'b0, a, b, 1'b0};
      req_valid = 1'b1;
      @(negedge ref_clk);
      req_valid = 1'b0;
      chk(err_decl, ee);
      chk(m_ill_rsp_valid, ei);
      chk(err_tid, 8'h33);
      if (ei)
         chk(m_ill_rsp_tid, 8'h33);
      clr("master_request");
   endtask : mreq

   task automatic mrd(input logic e);
      m_rd_datavalid = 1'b1;
      m_rd_last = 1'b1;
      m_rd_readerror = e;
      @(negedge ref_clk);
      m_rd_datavalid = 1'b0;
      m_rd_last = 1'b0;
      chk(m_rd_rsp_valid, 1'b1);
      chk(m_rd_rsp_status, e ? ST_ERROR : ST_DONE);
      clr("master_read");
   endtask : mrd

   task automatic unsol();
      fe_kick = 1'b1;
      @(negedge ref_clk);
      fe_kick = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk(err_seen.unsol, 1'b1);
      clr("unsolicited");
   endtask : unsol

   task automatic pt(input logic tg);
      rx_pkt_valid = 1'b1;
      rx_targeted = tg;
      pt_tx_error = 1'b1;
      msg_err_in = 4'ha;
      @(negedge ref_clk);
      rx_pkt_valid = 1'b0;
      pt_tx_error = 1'b0;
      chk(pt_rx_fwd, !tg);
      chk(pt_tx_abort, 1'b1);
      chk(msg_err_out, 4'ha);
      clr("pass_through");
   endtask : pt

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {ref_clk, rst_n, pw_rx_valid, pw_buf_full, s_rd_read, s_wr_write, req_valid, fe_kick} = '0;
      {m_rd_datavalid, m_rd_last, m_rd_readerror, rx_pkt_valid, rx_targeted, pt_tx_error} = '0;
      {pw_receive_allow, win_en, rx_crc_ok} = 3'b111;
      {pw_rx, req, s_rd_addr, s_wr_addr, s_rd_burstcount, s_wr_burstcount, msg_err_in} = '0;
      {flag_clr, win_base, fe_mode, fe_pl, s_wr_byteenable} = '0;
      int_en = 6'h21;
      dest_ops = 6'h0f;
      win_mask = 32'hffff0000;
      rsp_timeout = 24'h000014;
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      @(negedge ref_clk);
      pw(9'h000, 1'b1, 1'b0, 6'h01, 1'b0);
      pw(9'h041, 1'b1, 1'b0, 6'h01, 1'b0);
      pw(9'h010, 1'b1, 1'b0, 6'h01, 1'b0);
      pw(9'h008, 1'b1, 1'b0, 6'h00, 1'b1);
      pw(9'h008, 1'b0, 1'b0, 6'h02, 1'b0);
      pw(9'h008, 1'b1, 1'b1, 6'h02, 1'b0);
      rd(32'h00000100, 5'h02, 2'h0, 1'b0);
      chk(err_seen, 5'h00);
      chk(s_rd_readdata, 32'hc0de0001);
      chk(s_req_addr, 32'h00000100);
      clr("read_hit");
      rd(32'h00000100, 5'h02, 2'h1, 1'b1);
      chk(err_seen.io_err, 1'b1);
      clr("read_error");
      rd(32'h00000100, 5'h01, 2'h2, 1'b1);
      chk(err_seen.timeout, 1'b1);
      clr("read_timeout");
      rd(32'h00000100, 5'h01, 2'h3, 1'b1);
      chk(err_seen.illegal, 1'b1);
      clr("read_bad_status");
      rd(32'h00010000, MAX_BURST, 2'h0, 1'b1);
      rd(32'h00010000, 5'h02, 2'h0, 1'b1);
      chkf(6'h20);
      clr("read_miss");
      unsol();
      wr(32'h00000100, 4'h5, 5'h01, 6'h04);
      wr(32'h00000100, 4'hf, 5'h11, 6'h08);
      wr(32'h00010000, 4'hf, 5'h01, 6'h10);
      wr(32'h00000100, 4'hf, 5'h01, 6'h00);
      chk(s_req_kind, KIND_NWRITER);
      mreq(KIND_NREAD, 2'h0, 9'h000, 32'h100, 5'h00, 1'b0);
      mreq(KIND_NREAD, 2'h3, 9'h000, 32'h100, 5'h02, 1'b1);
      mreq(KIND_NWRITE, 2'h0, 9'h000, 32'h100, 5'h02, 1'b0);
      mreq(KIND_NWRITER, 2'h0, 9'h004, 32'h100, 5'h02, 1'b1);
      mreq(KIND_NREAD, 2'h0, 9'h008, 32'h100, 5'h02, 1'b1);
      mreq(KIND_SWRITE, 2'h0, 9'h008, 32'h10000, 5'h02, 1'b0);
      mreq(KIND_ATOMIC5, 2'h0, 9'h000, 32'h100, 5'h01, 1'b0);
      mreq(KIND_OTHER, 2'h0, 9'h000, 32'h100, 5'h01, 1'b0);
      dest_ops = 6'h1f;
      mreq(KIND_ATOMIC5, 2'h3, 9'h000, 32'h100, 5'h02, 1'b1);
      mrd(1'b1);
      mrd(1'b0);
      pt(1'b0);
      pt(1'b1);
      report_and_stop();
   end
endmodule : tb_top
